// [logic/ctlr_top.sv]
// Comparator trip latch, filter front end, ramp generator and Wishbone registers
//
// Functional notes
// - Trip latch holds until software clear or pwm sync pulse.
// - Latch sets only from filtered comparator output, never raw.
// - Worst-case latency is 4 + threshold times (divider + 1) clocks.
// - Filter may present stale history for one more latency after clear.
// - Filter high at clear sets latch again on next clock.
// - Filter output state readable in comparator status register.
// - Filter reinit through trip filter control flushes sample history.
// - Ramp decrements DAC value from each pwm sync pulse.
// - High comparator status flag stops the ramp decrement.
// - Trip coincident with sync wins; ramp halts until a sync finds the latch clear.
`timescale 1ns/1ns
module ctlr_top
   import ctlr_pkg::*;
#(
   parameter int unsigned HIST_DEPTH = 32
)(
   input  wire logic              CLK_SYS_I,
   input  wire logic              RESETN_I,
   input  wire logic              WB_CYC_I,
   input  wire logic              WB_STB_I,
   input  wire logic              WB_WE_I,
   input  wire logic [ADDR_W-1:0] WB_ADR_I,
   input  wire logic [3:0]        WB_SEL_I,
   input  wire logic [31:0]       WB_DAT_I,
   output logic       [31:0]      WB_DAT_O,
   output logic                   WB_ACK_O,
   input  wire logic              COMP_HIGH_I,
   input  wire logic              PWM_SYNC_PULSE_I,
   output logic                   TRIP_O,
   output logic       [DAC_W-1:0] DAC_VALUE_O,
   output logic                   IRQ_O
);
   logic [SYNC_STAGES-1:0] comp_sync_ff;
   logic [SYNC_STAGES-1:0] pwm_sync_ff;
   logic                   pwm_sync_d_ff;
   logic                   comp_q;
   logic                   pwm_sync_pulse;
   logic                   filt_out;
   logic                   trip_latch_ff;
   logic                   high_flag;
   logic [DIV_W-1:0]       div_ff;
   logic [THR_W-1:0]       thr_ff;
   logic                   filt_init_ff;
   logic                   sync_clr_en_ff;
   logic [DAC_W-1:0]       ramp_start_ff;
   logic [DAC_W-1:0]       ramp_step_ff;
   logic [DAC_W-1:0]       dac_ff;
   ctlr_ramp_t             ramp_state_ff;
   logic [IRQ_W-1:0]       irq_st_ff;
   logic [IRQ_W-1:0]       irq_mask_ff;
   logic [IRQ_W-1:0]       irq_evt;
   logic                   wb_req;
   logic                   wb_wr;
   logic                   wb_rd;
   logic                   sw_clear;
   logic [31:0]            nxt_rdata;

   function automatic logic hit(input logic [ADDR_W-1:0] adr, input logic [7:0] off);
      hit = (adr[ADDR_W-1:2] == off[ADDR_W-1:2]);
   endfunction

   // Two-stage synchronisers for external levels
   always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         comp_sync_ff  <= '0;
         pwm_sync_ff   <= '0;
         pwm_sync_d_ff <= 1'b0;
      end
      else
      begin
         comp_sync_ff  <= {comp_sync_ff[SYNC_STAGES-2:0], COMP_HIGH_I};
         pwm_sync_ff   <= {pwm_sync_ff[SYNC_STAGES-2:0], PWM_SYNC_PULSE_I};
         pwm_sync_d_ff <= pwm_sync_ff[SYNC_STAGES-1];
      end
   end

   assign comp_q         = comp_sync_ff[SYNC_STAGES-1];
   assign pwm_sync_pulse = pwm_sync_ff[SYNC_STAGES-1] && !pwm_sync_d_ff;

   ctlr_filter #(
      .DEPTH   (HIST_DEPTH)
   ) u_filter (
      .clk_i   (CLK_SYS_I),
      .rst_n_i (RESETN_I),
      .sample_i(comp_q),
      .div_i   (div_ff),
      .thr_i   (thr_ff),
      .flush_i (filt_init_ff),
      .out_o   (filt_out)
   );

   // Wishbone classic slave, one wait state
   assign wb_req   = WB_CYC_I && WB_STB_I && !WB_ACK_O;
   assign wb_wr    = wb_req && WB_WE_I;
   assign wb_rd    = wb_req && !WB_WE_I;
   assign sw_clear = wb_wr && hit(WB_ADR_I, REG_CLEAR) && WB_SEL_I[0]
                     && WB_DAT_I[CLR_LATCH_BIT];

   always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
         WB_ACK_O <= 1'b0;
      else
         WB_ACK_O <= wb_req;
   end

   // Trip latch: clear takes effect, filter high re-sets next cycle
   always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
         trip_latch_ff <= 1'b0;
      else if (sw_clear || (pwm_sync_pulse && sync_clr_en_ff))
         trip_latch_ff <= 1'b0;
      else if (filt_out)
         trip_latch_ff <= 1'b1;
   end

   assign high_flag = trip_latch_ff;
   assign TRIP_O    = trip_latch_ff;

   // Control registers
   always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         div_ff         <= RST_DIV;
         thr_ff         <= RST_THR;
         sync_clr_en_ff <= 1'b0;
         ramp_start_ff  <= RST_RAMP_START;
         ramp_step_ff   <= RST_RAMP_STEP;
         irq_mask_ff    <= RST_IRQ_MASK;
      end
      else if (wb_wr)
      begin
         if (hit(WB_ADR_I, REG_FILTER))
         begin
            if (WB_SEL_I[0])
               div_ff <= WB_DAT_I[FC_DIV_LSB +: DIV_W];
            if (WB_SEL_I[1])
               thr_ff <= WB_DAT_I[FC_THR_LSB +: THR_W];
            if (WB_SEL_I[2])
               sync_clr_en_ff <= WB_DAT_I[FC_SRC_BIT];
         end
         if (hit(WB_ADR_I, REG_RAMP_START) && WB_SEL_I[0])
            ramp_start_ff[7:0] <= WB_DAT_I[7:0];
         if (hit(WB_ADR_I, REG_RAMP_START) && WB_SEL_I[1])
            ramp_start_ff[DAC_W-1:8] <= WB_DAT_I[DAC_W-1:8];
         if (hit(WB_ADR_I, REG_RAMP_STEP) && WB_SEL_I[0])
            ramp_step_ff[7:0] <= WB_DAT_I[7:0];
         if (hit(WB_ADR_I, REG_RAMP_STEP) && WB_SEL_I[1])
            ramp_step_ff[DAC_W-1:8] <= WB_DAT_I[DAC_W-1:8];
         if (hit(WB_ADR_I, REG_IRQ_MASK) && WB_SEL_I[0])
            irq_mask_ff <= WB_DAT_I[IRQ_W-1:0];
      end
   end

   always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
         filt_init_ff <= 1'b0;
      else
         filt_init_ff <= wb_wr && hit(WB_ADR_I, REG_FILTER) && WB_SEL_I[2]
                         && WB_DAT_I[FC_INIT_BIT];
   end

   // Falling ramp generator
   always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         ramp_state_ff <= CTLR_RAMP_IDLE;
         dac_ff        <= RST_RAMP_START;
      end
      else
      begin
         unique case (ramp_state_ff)
            CTLR_RAMP_IDLE, CTLR_RAMP_HALT:
            begin
               if (pwm_sync_pulse && !high_flag)
               begin
                  ramp_state_ff <= CTLR_RAMP_RUN;
                  dac_ff        <= ramp_start_ff;
               end
            end
            CTLR_RAMP_RUN:
            begin
               if (high_flag)
                  ramp_state_ff <= CTLR_RAMP_HALT;
               else if (pwm_sync_pulse)
                  dac_ff <= ramp_start_ff;
               else if (dac_ff > ramp_step_ff)
                  dac_ff <= dac_ff - ramp_step_ff;
               else
                  dac_ff <= '0;
            end
            default:
               ramp_state_ff <= CTLR_RAMP_IDLE;
         endcase
      end
   end

   assign DAC_VALUE_O = dac_ff;

   // Sticky events, set wins over read clear
   assign irq_evt[IRQ_TRIP_BIT] = filt_out && !trip_latch_ff;
   assign irq_evt[IRQ_SYNC_BIT] = pwm_sync_pulse;
   assign irq_evt[IRQ_COLL_BIT] = pwm_sync_pulse && high_flag;

   always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
         irq_st_ff <= '0;
      else if (wb_rd && hit(WB_ADR_I, REG_IRQ_STATUS))
         irq_st_ff <= irq_evt;
      else
         irq_st_ff <= irq_st_ff | irq_evt;
   end

   always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
         IRQ_O <= 1'b0;
      else
         IRQ_O <= |(irq_st_ff & irq_mask_ff);
   end

   // Read mux; unmapped reads zero
   always_comb
   begin
      nxt_rdata = '0;
      if (hit(WB_ADR_I, REG_STATUS))
      begin
         nxt_rdata[ST_FILTER_BIT] = filt_out;
         nxt_rdata[ST_LATCH_BIT]  = trip_latch_ff;
         nxt_rdata[ST_HIGH_BIT]   = high_flag;
         nxt_rdata[ST_RAMP_BIT]   = (ramp_state_ff == CTLR_RAMP_RUN);
      end
      else if (hit(WB_ADR_I, REG_FILTER))
      begin
         nxt_rdata[FC_DIV_LSB +: DIV_W] = div_ff;
         nxt_rdata[FC_THR_LSB +: THR_W] = thr_ff;
         nxt_rdata[FC_SRC_BIT]          = sync_clr_en_ff;
      end
      else if (hit(WB_ADR_I, REG_RAMP_START))
         nxt_rdata[DAC_W-1:0] = ramp_start_ff;
      else if (hit(WB_ADR_I, REG_RAMP_STEP))
         nxt_rdata[DAC_W-1:0] = ramp_step_ff;
      else if (hit(WB_ADR_I, REG_DAC_VALUE))
         nxt_rdata[DAC_W-1:0] = dac_ff;
      else if (hit(WB_ADR_I, REG_IRQ_STATUS))
         nxt_rdata[IRQ_W-1:0] = irq_st_ff;
      else if (hit(WB_ADR_I, REG_IRQ_MASK))
         nxt_rdata[IRQ_W-1:0] = irq_mask_ff;
   end

   always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
         WB_DAT_O <= '0;
      else if (wb_rd)
         WB_DAT_O <= nxt_rdata;
   end
endmodule

// [logic/ctlr_pkg.sv]
// Package: register map, fields, reset values and widths of the trip latch block
package ctlr_pkg;
   localparam int unsigned ADDR_W        = 8;
   localparam int unsigned DAC_W         = 12;
   localparam int unsigned DIV_W         = 8;
   localparam int unsigned THR_W         = 5;
   // Register byte offsets
   localparam logic [7:0] REG_STATUS     = 8'h00;
   localparam logic [7:0] REG_CLEAR      = 8'h04;
   localparam logic [7:0] REG_FILTER     = 8'h08;
   localparam logic [7:0] REG_RAMP_START = 8'h0c;
   localparam logic [7:0] REG_RAMP_STEP  = 8'h10;
   localparam logic [7:0] REG_DAC_VALUE  = 8'h14;
   localparam logic [7:0] REG_IRQ_STATUS = 8'h18;
   localparam logic [7:0] REG_IRQ_MASK   = 8'h1c;
   // Status register fields
   localparam int unsigned ST_FILTER_BIT = 0;
   localparam int unsigned ST_LATCH_BIT  = 1;
   localparam int unsigned ST_HIGH_BIT   = 2;
   localparam int unsigned ST_RAMP_BIT   = 3;
   // Clear register fields
   localparam int unsigned CLR_LATCH_BIT = 0;
   // Filter control fields
   localparam int unsigned FC_DIV_LSB    = 0;
   localparam int unsigned FC_THR_LSB    = 8;
   localparam int unsigned FC_INIT_BIT   = 16;
   localparam int unsigned FC_SRC_BIT    = 17;
   // Interrupt status fields
   localparam int unsigned IRQ_TRIP_BIT  = 0;
   localparam int unsigned IRQ_SYNC_BIT  = 1;
   localparam int unsigned IRQ_COLL_BIT  = 2;
   localparam int unsigned IRQ_W         = 3;
   // Reset values and synchroniser depth
   localparam logic [DIV_W-1:0] RST_DIV  = 8'h01;
   localparam logic [THR_W-1:0] RST_THR  = 5'h01;
   localparam logic [DAC_W-1:0] RST_RAMP_START = 12'hfff;
   localparam logic [DAC_W-1:0] RST_RAMP_STEP  = 12'h001;
   localparam logic [IRQ_W-1:0] RST_IRQ_MASK   = 3'h0;
   localparam int unsigned SYNC_STAGES   = 2;
   // Ramp states
   typedef enum logic [1:0] {
      CTLR_RAMP_IDLE = 2'b00,
      CTLR_RAMP_RUN  = 2'b01,
      CTLR_RAMP_HALT = 2'b11
   } ctlr_ramp_t;
endpackage

// [logic/ctlr_filter.sv]
// Unanimous-vote digital filter with clock divider and flushable sample history
`timescale 1ns/1ns
module ctlr_filter
   import ctlr_pkg::*;
#(
   parameter int unsigned DEPTH = 32
)(
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   input  wire logic             sample_i,
   input  wire logic [DIV_W-1:0] div_i,
   input  wire logic [THR_W-1:0] thr_i,
   input  wire logic             flush_i,
   output logic                  out_o
);
   logic [DIV_W-1:0] div_cnt_ff;
   logic [DEPTH-1:0] hist_ff;
   logic [5:0]       ones;
   logic [5:0]       zeros;
   logic             tick;
   logic [THR_W-1:0] thr_eff;

   assign tick    = (div_cnt_ff >= div_i);
   assign thr_eff = (thr_i == '0) ? THR_W'(1) : thr_i;

   // Divided sample tick
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         div_cnt_ff <= '0;
      else if (flush_i || tick)
         div_cnt_ff <= '0;
      else
         div_cnt_ff <= div_cnt_ff + DIV_W'(1);
   end

   // Sample history, cleared by reinit
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         hist_ff <= '0;
      else if (flush_i)
         hist_ff <= '0;
      else if (tick)
         hist_ff <= {hist_ff[DEPTH-2:0], sample_i};
   end

   // Count agreeing samples in the vote window
   always_comb
   begin
      ones  = '0;
      zeros = '0;
      for (int i = 0; i < DEPTH; i++)
      begin
         if (i < int'(thr_eff))
         begin
            if (hist_ff[i])
               ones = ones + 6'h01;
            else
               zeros = zeros + 6'h01;
         end
      end
   end

   // Output changes only on unanimous vote or reinit
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         out_o <= 1'b0;
      else if (flush_i)
         out_o <= 1'b0;
      else if (ones == 6'(thr_eff))
         out_o <= 1'b1;
      else if (zeros == 6'(thr_eff))
         out_o <= 1'b0;
   end
endmodule

// [verification/ctlr_pwm_model.sv]
// Pwm module model: sync pulses on command
`timescale 1ns/1ns
module ctlr_pwm_model
#(
   parameter int unsigned HOLD = 4
)(
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic fire_i,
   output logic      sync_o
);
   logic [4:0] left_ff;
   // High for HOLD cycles, then low as long
   assign sync_o = left_ff > 5'(HOLD);
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         left_ff <= 5'h0;
      else if (fire_i && left_ff == 5'h0)
         left_ff <= 5'(2 * HOLD);
      else if (left_ff != 5'h0)
         left_ff <= left_ff - 5'h1;
   end
endmodule

// [verification/ctlr_top_assertions.sv]
// Concurrent checks on the trip latch block ports
`timescale 1ns/1ns
module ctlr_top_assertions
   import ctlr_pkg::*;
(
   input wire logic              CLK_SYS_I,
   input wire logic              RESETN_I,
   input wire logic              WB_CYC_I,
   input wire logic              WB_STB_I,
   input wire logic              WB_WE_I,
   input wire logic [ADDR_W-1:0] WB_ADR_I,
   input wire logic [3:0]        WB_SEL_I,
   input wire logic [31:0]       WB_DAT_I,
   input wire logic [31:0]       WB_DAT_O,
   input wire logic              WB_ACK_O,
   input wire logic              COMP_HIGH_I,
   input wire logic              PWM_SYNC_PULSE_I,
   input wire logic              TRIP_O,
   input wire logic [DAC_W-1:0]  DAC_VALUE_O,
   input wire logic              IRQ_O
);
   logic       cfg_ff;
   logic [4:0] hi_ff;
   wire logic  take_w = WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O;
   wire logic  clr_w  = take_w && WB_ADR_I == REG_CLEAR && WB_DAT_I[0];
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (!RESETN_I);
   // Filter reconfigured, long comparator high run
   always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         cfg_ff <= 1'b0;
         hi_ff  <= 5'h0;
      end
      else
      begin
         cfg_ff <= cfg_ff || (take_w && WB_ADR_I == REG_FILTER);
         hi_ff  <= !COMP_HIGH_I ? 5'h0 : (hi_ff == 5'h1f ? hi_ff : hi_ff + 5'h1);
      end
   end
   sequence req_s;
      WB_CYC_I && WB_STB_I && !WB_ACK_O;
   endsequence
   sequence sync_run_s;
      !TRIP_O && $rose(PWM_SYNC_PULSE_I) ##1 !TRIP_O [*7];
   endsequence
   ack_answer_a: assert property (req_s |=> WB_ACK_O)
      else $error("ack did not follow request");
   ack_single_a: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("ack longer than one cycle");
   ack_idle_a: assert property (!WB_CYC_I |=> !WB_ACK_O)
      else $error("ack without cycle");
   trip_clear_a: assert property ($fell(TRIP_O) |->
      $past(clr_w) || $past(PWM_SYNC_PULSE_I, 3)) else $error("latch dropped by itself");
   trip_filt_a: assert property ($rose(COMP_HIGH_I) && !TRIP_O |=> !TRIP_O [*4])
      else $error("latch set before filter");
   trip_lat_a: assert property ($rose(COMP_HIGH_I) && !TRIP_O && !cfg_ff |->
      ##[3:6] (TRIP_O || !COMP_HIGH_I)) else $error("trip latency too long");
   latch_refill_a: assert property ($fell(TRIP_O) && hi_ff >= 5'h08 && !cfg_ff |=> TRIP_O)
      else $error("latch did not set again");
   dac_hold_a: assert property (TRIP_O [*2] |=> $stable(DAC_VALUE_O))
      else $error("ramp moved while tripped");
   ramp_run_a: assert property (sync_run_s |-> DAC_VALUE_O < $past(DAC_VALUE_O))
      else $error("ramp not falling after sync");
endmodule
bind ctlr_top ctlr_top_assertions chk (.CLK_SYS_I(CLK_SYS_I), .RESETN_I(RESETN_I),
   .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
   .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
   .COMP_HIGH_I(COMP_HIGH_I), .PWM_SYNC_PULSE_I(PWM_SYNC_PULSE_I), .TRIP_O(TRIP_O),
   .DAC_VALUE_O(DAC_VALUE_O), .IRQ_O(IRQ_O));

// [verification/tb_ctlr_top.sv]
// Self-checking bench for the trip latch block
`timescale 1ns/1ns
module tb_ctlr_top
   import ctlr_pkg::*;
;
   logic        clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, comp = 0, fire = 0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, got;
   logic        ack, sync, trip, irq;
   logic [11:0] dac, v;
   int          num_errors = 0, checks = 0, n;
   logic [7:0]  ra [7] = '{REG_STATUS, REG_FILTER, REG_RAMP_START, REG_RAMP_STEP,
                           REG_IRQ_MASK, REG_DAC_VALUE, 8'h20};
   logic [31:0] rv [7] = '{32'h0, 32'h101, 32'hfff, 32'h1, 32'h0, 32'hfff, 32'h0};
   always #5 clk = ~clk;
   ctlr_top dut (.CLK_SYS_I(clk), .RESETN_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
      .WB_ACK_O(ack), .COMP_HIGH_I(comp), .PWM_SYNC_PULSE_I(sync), .TRIP_O(trip),
      .DAC_VALUE_O(dac), .IRQ_O(irq));
   ctlr_pwm_model pwm (.clk_i(clk), .rst_n_i(rst_n), .fire_i(fire), .sync_o(sync));
   task automatic check(input string nm, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_of_test();
      if (num_errors == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge clk);
      while (ack !== 1'b1)
         @(posedge clk);
      got = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      check("read", got, e);
   endtask
   task automatic wait_trip();
      n = 0;
      while (trip !== 1'b1 && n < 60)
      begin
         @(posedge clk);
         n++;
      end
      if (n == 60)
         num_errors++;
   endtask
   task automatic pulse();
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      repeat (10) @(posedge clk);
   endtask
   initial
   begin
      #100000;
      num_errors++;
      end_of_test();
   end
   initial
   begin
      repeat (12) @(posedge clk);
      check("trip", trip, 0);
      check("dac", dac, 32'hfff);
      check("irq", irq, 0);
      rst_n <= 1'b1;
      @(posedge clk);
      foreach (ra[i])
         rd(ra[i], rv[i]);
      comp <= 1'b1;
      wait_trip();
      check("latency", n >= 4 && n <= 9, 1);
      rd(REG_STATUS, 32'h7);
      check("irq", irq, 0);
      bus(1'b1, REG_IRQ_MASK, 32'h1);
      check("irq", irq, 1);
      rd(REG_IRQ_STATUS, 32'h1);
      @(posedge clk);
      check("irq", irq, 0);
      bus(1'b1, REG_CLEAR, 32'h1);
      check("trip", trip, 1);
      comp <= 1'b0;
      repeat (12) @(posedge clk);
      check("trip", trip, 1);
      rd(REG_STATUS, 32'h6);
      bus(1'b1, REG_CLEAR, 32'h1);
      check("trip", trip, 0);
      pulse();
      check("ramp", dac < 12'hfff, 1);
      rd(REG_STATUS, 32'h8);
      comp <= 1'b1;
      wait_trip();
      repeat (2) @(posedge clk);
      v = dac;
      repeat (6) @(posedge clk);
      check("dac", dac, v);
      pulse();
      check("dac", dac, v);
      rd(REG_STATUS, 32'h7);
      rd(REG_IRQ_STATUS, 32'h7);
      comp <= 1'b0;
      bus(1'b1, REG_FILTER, 32'h20101);
      repeat (12) @(posedge clk);
      // comparator low well before the sync; the sync clears the trip
      pulse();
      check("trip", trip, 0);
      bus(1'b1, REG_FILTER, 32'h801);
      comp <= 1'b1;
      repeat (40) @(posedge clk);
      check("trip", trip, 1);
      comp <= 1'b0;
      bus(1'b1, REG_FILTER, 32'h10801);
      rd(REG_STATUS, 32'h6);
      bus(1'b1, REG_CLEAR, 32'h1);
      repeat (3) @(posedge clk);
      check("trip", trip, 0);
      end_of_test();
   end
endmodule
